// *** logic/see_pkg.sv ***
`default_nettype none
package see_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned PROG_TIME_MS = 5;
  // longest program time counted in whole clock cycles
  localparam int unsigned PROG_CYC     = PROG_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned SCL_KHZ      = 400;
  localparam int unsigned SCL_QTR_CYC  = (CLK_MHZ * 1000) / (SCL_KHZ * 4);

  // ==========================================================
  // array geometry
  localparam int unsigned MEM_DEPTH   = 2048;
  localparam int unsigned PTR_W       = 11;
  localparam int unsigned PAGE_BYTES  = 16;
  localparam int unsigned PAGE_W      = 4;
  localparam logic [7:0]  ERASED_BYTE = 8'hff;

  // ==========================================================
  // target address byte layout
  localparam logic        ADDR_FIXED  = 1'b1;
  localparam int unsigned ADDR_CS_LSB = 4;
  localparam int unsigned ADDR_BLK_LSB = 1;
  localparam int unsigned ADDR_RW_BIT = 0;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;

  // ==========================================================
  // reset values
  localparam logic [5:0]  PIN_SYNC_RST = 6'h30;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    D_IDLE,
    D_ADDR,
    D_WORD,
    D_DATA,
    D_RD,
    D_BUSY
  } see_dev_st_e;

  typedef enum logic [1:0] {
    OP_START,
    OP_STOP,
    OP_WRITE,
    OP_READ
  } see_op_e;

endpackage
`default_nettype wire

// *** logic/see_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface see_if;
  // serial clock, made by the controller only
  logic scl;
  // open-drain data: each end pulls low while its enable is low
  logic host_sda_o;
  logic host_sda_oe_b;
  logic dev_sda_o;
  logic dev_sda_oe_b;
  logic sda;

  // ==========================================================
  // wired-and of both ends with the pull-up
  assign sda = (host_sda_oe_b | host_sda_o) & (dev_sda_oe_b | dev_sda_o);

  modport host (
    output scl,
    output host_sda_o,
    output host_sda_oe_b,
    input  sda
  );

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe_b
  );
endinterface
`default_nettype wire

// *** logic/see_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
// Contract
// - page of 16 bytes, one program cycle
// - controller sends up to fifteen extra bytes
// - ack each byte, bump low four bits
// - over sixteen bytes wraps, overwrites buffer
// - program starts only at stop
// - controller may poll right after stop
// - nack target address while programming
// - ack address once done, then continue
// - protect high blocks every array write
// - sample protect at fall before data
// - protected: nack first data, discard write
// - array starts all ones
// - read address: ack, send current byte
// - nack then stop ends read
// - random read: dummy write, restart, read
// - random read returns chosen byte, nacked
// - acked read bytes keep streaming
// - read pointer wraps at memory end
// - address byte: one, selects, block, direction
// - byte after write address loads pointer
// - release data, ignore all while programming
module see_dev
  import see_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // two-wire link
  see_if.dev        bus,
  // protect and chip-select straps
  input  wire logic wp,
  input  wire logic chip_select_bit_high,
  input  wire logic chip_select_bit_mid,
  input  wire logic chip_select_bit_low,
  // status
  output logic      busy
);

  localparam int unsigned PROG_W = $clog2(PROG_CYCLES + 1);

  // ==========================================================
  // pin synchronisers
  logic [5:0]        pin_s1_q;
  logic [5:0]        pin_s2_q;
  logic              scl_p_q;
  logic              sda_p_q;
  wire  logic [5:0]  pin_raw;
  wire  logic        scl_s;
  wire  logic        sda_s;
  wire  logic        wp_s;
  wire  logic [2:0]  cs_s;

  assign pin_raw = {bus.scl, bus.sda, wp, chip_select_bit_high,
                    chip_select_bit_mid, chip_select_bit_low};
  assign scl_s   = pin_s2_q[5];
  assign sda_s   = pin_s2_q[4];
  assign wp_s    = pin_s2_q[3];
  assign cs_s    = pin_s2_q[2:0];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_s1_q <= PIN_SYNC_RST;
      pin_s2_q <= PIN_SYNC_RST;
      scl_p_q  <= 1'b1;
      sda_p_q  <= 1'b1;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      scl_p_q  <= scl_s;
      sda_p_q  <= sda_s;
    end
  end

  // ==========================================================
  // state
  see_dev_st_e             st_q;
  logic [3:0]              cnt_q;
  logic [7:0]              sh_q;
  logic                    ack_q;
  logic                    rw_q;
  logic                    mack_q;
  logic                    wp_blk_q;
  logic [PTR_W-1:0]        ptr_q;
  logic                    oe_b_q;
  logic                    busy_q;
  logic [PROG_W-1:0]       prog_cnt_q;
  logic [7:0]              mem_q [MEM_DEPTH];
  logic [7:0]              buf_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0]   bval_q;

  // ==========================================================
  // event decode
  wire logic        scl_rise;
  wire logic        scl_fall;
  wire logic        ev_start;
  wire logic        ev_stop;
  wire logic        rx_st;
  wire logic        byte_done;
  wire logic        addr_hit;
  wire logic        ev_store;
  wire logic        ev_prog;
  wire logic        rd_next;
  wire logic        prog_done;
  wire logic [7:0]  rd_byte;

  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign ev_start  = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign ev_stop   = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign rx_st     = (st_q == D_ADDR) | (st_q == D_WORD) | (st_q == D_DATA);
  assign byte_done = scl_fall & rx_st & ~ack_q & (cnt_q == BYTE_BITS);
  assign addr_hit  = sh_q[7:ADDR_CS_LSB] ==
                     {ADDR_FIXED, cs_s[2], ~cs_s[1], cs_s[0]};
  assign ev_store  = byte_done & (st_q == D_DATA) & ~wp_blk_q;
  assign ev_prog   = ev_stop & (st_q == D_DATA) & (|bval_q) & ~wp_blk_q;
  assign rd_next   = scl_fall & ack_q &
                     (((st_q == D_ADDR) & rw_q) | ((st_q == D_RD) & mack_q));
  assign prog_done = prog_cnt_q == PROG_W'(PROG_CYCLES - 1);
  assign rd_byte   = mem_q[ptr_q];

  // ==========================================================
  // array: erased at power-up, only the buffered bytes of the page committed at once
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_q[i] <= ERASED_BYTE;
      end
    end else if (ev_prog) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (bval_q[i]) begin
          mem_q[{ptr_q[PTR_W-1:PAGE_W], PAGE_W'(i)}] <= buf_q[i];
        end
      end
    end
  end

  // ==========================================================
  // page buffer; a later byte at the same slot replaces the older
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bval_q <= '0;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        buf_q[i] <= '0;
      end
    end else if (ev_start | ev_prog) begin
      bval_q <= '0;
    end else if (ev_store) begin
      buf_q[ptr_q[PAGE_W-1:0]]  <= sh_q;
      bval_q[ptr_q[PAGE_W-1:0]] <= 1'b1;
    end
  end

  // ==========================================================
  // protocol engine
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q       <= D_IDLE;
      cnt_q      <= '0;
      sh_q       <= '0;
      ack_q      <= 1'b0;
      rw_q       <= 1'b0;
      mack_q     <= 1'b0;
      wp_blk_q   <= 1'b0;
      ptr_q      <= '0;
      oe_b_q     <= 1'b1;
      busy_q     <= 1'b0;
      prog_cnt_q <= '0;
    end else if (st_q == D_BUSY) begin
      // deaf to the bus, so a poll is simply not acknowledged
      oe_b_q <= 1'b1;
      if (prog_done) begin
        st_q   <= D_IDLE;
        busy_q <= 1'b0;
      end else begin
        prog_cnt_q <= prog_cnt_q + 1'b1;
      end
    end else if (ev_start) begin
      st_q   <= D_ADDR;
      cnt_q  <= '0;
      ack_q  <= 1'b0;
      oe_b_q <= 1'b1;
    end else if (ev_stop) begin
      ack_q  <= 1'b0;
      oe_b_q <= 1'b1;
      if (ev_prog) begin
        st_q       <= D_BUSY;
        busy_q     <= 1'b1;
        prog_cnt_q <= '0;
      end else begin
        st_q <= D_IDLE;
      end
    end else if (scl_rise & ~ack_q & (rx_st | (st_q == D_RD))) begin
      cnt_q <= cnt_q + 1'b1;
      if (rx_st) begin
        sh_q <= {sh_q[6:0], sda_s};
      end
    end else if (scl_rise & ack_q & (st_q == D_RD)) begin
      mack_q <= ~sda_s;
    end else if (byte_done) begin
      cnt_q <= '0;
      if (st_q == D_ADDR) begin
        if (addr_hit) begin
          ack_q                 <= 1'b1;
          oe_b_q                <= 1'b0;
          ptr_q[PTR_W-1:8]      <= sh_q[3:ADDR_BLK_LSB];
          rw_q                  <= sh_q[ADDR_RW_BIT];
        end else begin
          st_q <= D_IDLE;
        end
      end else if (st_q == D_WORD) begin
        ptr_q[7:0] <= sh_q;
        ack_q      <= 1'b1;
        oe_b_q     <= 1'b0;
      end else if (wp_blk_q) begin
        st_q <= D_IDLE;
      end else begin
        ptr_q[PAGE_W-1:0] <= ptr_q[PAGE_W-1:0] + 1'b1;
        ack_q             <= 1'b1;
        oe_b_q            <= 1'b0;
      end
    end else if (rd_next) begin
      // first bit goes out on the same fall that ends the ack slot
      st_q   <= D_RD;
      ack_q  <= 1'b0;
      cnt_q  <= '0;
      oe_b_q <= rd_byte[7];
      sh_q   <= {rd_byte[6:0], 1'b1};
      ptr_q  <= ptr_q + 1'b1;
    end else if (scl_fall & ack_q) begin
      ack_q  <= 1'b0;
      oe_b_q <= 1'b1;
      if (st_q == D_ADDR) begin
        st_q <= D_WORD;
      end else if (st_q == D_WORD) begin
        st_q     <= D_DATA;
        wp_blk_q <= wp_s;
      end else if (st_q == D_RD) begin
        st_q <= D_IDLE;
      end
    end else if (scl_fall & (st_q == D_RD)) begin
      if (cnt_q == BYTE_BITS) begin
        ack_q  <= 1'b1;
        oe_b_q <= 1'b1;
      end else begin
        oe_b_q <= sh_q[7];
        sh_q   <= {sh_q[6:0], 1'b1};
      end
    end
  end

  // ==========================================================
  // outputs
  assign bus.dev_sda_o    = 1'b0;
  assign bus.dev_sda_oe_b = oe_b_q;
  assign busy             = busy_q;

endmodule
`default_nettype wire

// *** logic/see_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module see_host
  import see_pkg::*;
#(
  parameter int unsigned QTR_CYCLES = SCL_QTR_CYC,
  parameter int unsigned RSP_W      = 9
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // two-wire link
  see_if.host                   bus,
  // command port
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  input  wire see_op_e          cmd_op,
  input  wire logic [7:0]       cmd_data,
  // answer port, {byte, nack}
  output logic                  rsp_valid,
  input  wire logic             rsp_ready,
  output logic [RSP_W-1:0]      rsp_data
);

  localparam int unsigned QTR_W = $clog2(QTR_CYCLES + 1);

  // ==========================================================
  // sda synchroniser
  logic sda_s1_q;
  logic sda_s2_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      sda_s1_q <= bus.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  // ==========================================================
  // two-entry answer buffer; full stalls the command port
  logic [RSP_W-1:0]  head_q;
  logic [RSP_W-1:0]  tail_q;
  logic              head_v_q;
  logic              tail_v_q;
  logic              push;
  logic [RSP_W-1:0]  push_data;
  wire  logic        pop;

  assign pop = head_v_q & rsp_ready;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      head_q   <= '0;
      tail_q   <= '0;
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
    end else if (tail_v_q) begin
      if (pop) begin
        head_q   <= tail_q;
        tail_v_q <= 1'b0;
      end
    end else if (push & (~head_v_q | pop)) begin
      head_q   <= push_data;
      head_v_q <= 1'b1;
    end else if (push) begin
      tail_q   <= push_data;
      tail_v_q <= 1'b1;
    end else if (pop) begin
      head_v_q <= 1'b0;
    end
  end

  // ==========================================================
  // bit engine: four quarter-periods per bit
  logic               run_q;
  see_op_e            op_q;
  logic [QTR_W-1:0]   div_q;
  logic [1:0]         ph_q;
  logic [3:0]         bit_q;
  logic [8:0]         sh_q;
  logic [8:0]         rx_q;
  logic               scl_q;
  logic               oe_b_q;
  logic               rdy_q;
  wire  logic         tick;
  wire  logic         take;
  wire  logic         one_bit;
  wire  logic         last_bit;

  assign tick     = run_q & (div_q == QTR_W'(QTR_CYCLES - 1));
  assign take     = cmd_valid & rdy_q;
  assign one_bit  = (op_q == OP_START) | (op_q == OP_STOP);
  assign last_bit = one_bit | (bit_q == BYTE_BITS);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      push_data <= '0;
      push      <= 1'b0;
    end else begin
      push      <= tick & (ph_q == 2'd3) & last_bit & ~one_bit;
      push_data <= {rx_q[8:1], rx_q[0]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      run_q  <= 1'b0;
      op_q   <= OP_STOP;
      div_q  <= '0;
      ph_q   <= '0;
      bit_q  <= '0;
      sh_q   <= '1;
      rx_q   <= '0;
      scl_q  <= 1'b1;
      oe_b_q <= 1'b1;
      rdy_q  <= 1'b0;
    end else begin
      // a free tail slot is room enough; a held head alone does not block
      rdy_q <= ~run_q & ~take & ~tail_v_q & ~push;
      if (take) begin
        run_q <= 1'b1;
        op_q  <= cmd_op;
        div_q <= '0;
        ph_q  <= '0;
        bit_q <= '0;
        // read bytes send ones so the target drives the line
        sh_q  <= (cmd_op == OP_READ) ? {8'hff, cmd_data[0]} : {cmd_data, 1'b1};
      end else if (run_q) begin
        div_q <= tick ? '0 : div_q + 1'b1;
      end
      if (tick) begin
        ph_q <= ph_q + 1'b1;
        unique case (ph_q)
          2'd0: oe_b_q <= (op_q == OP_START) ? 1'b1 :
                          (op_q == OP_STOP)  ? 1'b0 : sh_q[8];
          2'd1: scl_q  <= 1'b1;
          2'd2: begin
            if (op_q == OP_START) begin
              oe_b_q <= 1'b0;
            end else if (op_q == OP_STOP) begin
              oe_b_q <= 1'b1;
            end else begin
              rx_q <= {rx_q[7:0], sda_s2_q};
            end
          end
          2'd3: begin
            scl_q <= (op_q == OP_STOP);
            sh_q  <= {sh_q[7:0], 1'b1};
            bit_q <= bit_q + 1'b1;
            if (last_bit) begin
              run_q <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // outputs
  assign bus.scl           = scl_q;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_sda_oe_b = oe_b_q;
  assign cmd_ready         = rdy_q;
  assign rsp_valid         = head_v_q;
  assign rsp_data          = head_q;

endmodule
`default_nettype wire

// *** test/see_chk_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module see_chk
  import see_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = 2000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link lines
  input wire logic scl,
  input wire logic host_sda_oe_b,
  input wire logic dev_sda_oe_b,
  input wire logic sda,
  // device status
  input wire logic busy
);
  logic        sda_q;
  logic        idle_q;
  logic        idle_d;
  logic [7:0]  since_q;
  logic [7:0]  since_d;
  logic [31:0] bcnt_q;
  logic [31:0] bcnt_d;
  wire logic   stop_seen  = scl & sda & ~sda_q;
  wire logic   start_seen = scl & ~sda & sda_q;

  // ==========================================================
  // helper state
  assign idle_d  = stop_seen ? 1'b1 : (start_seen ? 1'b0 : idle_q);
  assign since_d = stop_seen ? 8'h00 : ((since_q == 8'hff) ? since_q : since_q + 8'h01);
  assign bcnt_d  = busy ? bcnt_q + 32'h1 : 32'h0;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sda_q   <= 1'b1;
      idle_q  <= 1'b1;
      since_q <= 8'hff;
      bcnt_q  <= 32'h0;
    end else begin
      sda_q   <= sda;
      idle_q  <= idle_d;
      since_q <= since_d;
      bcnt_q  <= bcnt_d;
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_reset_lines_idle: assert property ($rose(rst_b) |-> scl && host_sda_oe_b && dev_sda_oe_b)
    else $error("link not idle after reset");
  a_scl_divided: assert property ($changed(scl) |=> $stable(scl) [*8])
    else $error("serial clock toggles too fast");
  a_busy_quiet: assert property (busy |-> dev_sda_oe_b)
    else $error("device drives data while programming");
  a_busy_from_stop: assert property ($rose(busy) |-> since_q <= 8'h08)
    else $error("programming started without a stop");
  a_busy_length: assert property ($past(rst_b) && $fell(busy) |->
    (bcnt_q + 2 >= PROG_CYCLES) && (bcnt_q <= PROG_CYCLES + 2))
    else $error("programming time wrong");
  a_dev_steady_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_b))
    else $error("device changed data while clock high");
  a_idle_released: assert property (idle_q |-> dev_sda_oe_b)
    else $error("device drives data between frames");
  a_idle_scl_high: assert property (idle_q |-> scl)
    else $error("serial clock low between frames");
  c_busy_seen: cover property ($fell(busy));
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import see_pkg::*;
();
  localparam int QTR  = 8;
  localparam int PROG = 2000;
  logic        clk       = 1'b0;
  logic        rst_b     = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        rsp_ready = 1'b1;
  logic        wp        = 1'b0;
  logic        cs_h      = 1'b0;
  logic        cs_m      = 1'b0;
  logic        cs_l      = 1'b0;
  see_op_e     cmd_op    = OP_START;
  logic [7:0]  cmd_data  = 8'h00;
  logic        cmd_ready;
  logic        rsp_valid;
  logic        busy;
  logic [8:0]  rsp_data;
  int          num_errors = 0;
  int          n_tests    = 0;
  int          cycles     = 0;
  int          seed       = 32'h30cf0e14;
  logic [7:0]  mem [0:2047];
  logic [7:0]  pend [int];
  logic [10:0] mptr       = 11'h000;

  always #2.5 clk = ~clk;

  see_if see_if_inst ();
  see_host #(.QTR_CYCLES(QTR), .RSP_W(9)) see_host_inst (.clk(clk), .rst_b(rst_b),
    .bus(see_if_inst.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data));
  see_dev #(.PROG_CYCLES(PROG)) see_dev_inst (.clk(clk), .rst_b(rst_b), .bus(see_if_inst.dev),
    .wp(wp), .chip_select_bit_high(cs_h), .chip_select_bit_mid(cs_m),
    .chip_select_bit_low(cs_l), .busy(busy));
  see_chk #(.PROG_CYCLES(PROG)) see_chk_inst (.clk(clk), .rst_b(rst_b), .scl(see_if_inst.scl),
    .host_sda_oe_b(see_if_inst.host_sda_oe_b), .dev_sda_oe_b(see_if_inst.dev_sda_oe_b),
    .sda(see_if_inst.sda), .busy(busy));

  // ==========================================================
  // shared tasks
  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] tadr(input logic [2:0] blk, input logic rd);
    return {1'b1, cs_h, ~cs_m, cs_l, blk, rd};
  endfunction

  // values read just after the edge are those the design sampled there
  task automatic op(input see_op_e o, input logic [7:0] d);
    @(posedge clk);
    cmd_op    <= o;
    cmd_data  <= d;
    cmd_valid <= 1'b1;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
  endtask

  task automatic rsp(input string what, input logic [8:0] exp);
    do @(posedge clk); while (rsp_valid !== 1'b1 || rsp_ready !== 1'b1);
    chk(what, exp, rsp_data);
  endtask

  task automatic wrx(input string what, input logic [7:0] b, input logic n);
    op(OP_WRITE, b);
    rsp(what, {b, n});
  endtask

  task automatic stop();
    op(OP_STOP, 8'h00);
    foreach (pend[k]) mem[k] = pend[k];
    pend.delete();
  endtask

  task automatic seta(input logic [10:0] a);
    op(OP_START, 8'h00);
    wrx("addr", tadr(a[10:8], 1'b0), 1'b0);
    wrx("word", a[7:0], 1'b0);
    mptr = a;
  endtask

  task automatic wdat(input logic [7:0] b);
    wrx("data", b, 1'b0);
    pend[mptr] = b;
    mptr[3:0] = mptr[3:0] + 4'h1;
  endtask

  task automatic rdseq(input int cnt);
    int i;
    op(OP_START, 8'h00);
    wrx("rd addr", tadr(mptr[10:8], 1'b1), 1'b0);
    for (i = 0; i < cnt; i++) begin
      op(OP_READ, {7'h00, i == cnt - 1});
      rsp("read", {mem[mptr], i == cnt - 1});
      mptr = mptr + 11'h1;
    end
    stop();
  endtask

  task automatic poll();
    int   i;
    logic n;
    n = 1'b1;
    for (i = 0; i < 30 && n; i++) begin
      op(OP_START, 8'h00);
      op(OP_WRITE, tadr(mptr[10:8], 1'b0));
      do @(posedge clk); while (rsp_valid !== 1'b1);
      n = rsp_data[0];
      if (i == 0) chk("first poll", {tadr(mptr[10:8], 1'b0), 1'b1}, rsp_data);
      stop();
    end
    chk("poll ack", 9'h000, {8'h00, n});
  endtask

  // ==========================================================
  // timeout
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors = num_errors + 1;
      test_done();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [10:0] a;
    logic [7:0]  b;
    int          i;
    for (i = 0; i < 2048; i++) mem[i] = ERASED_BYTE;
    repeat (12) @(posedge clk);
    {cs_h, cs_m, cs_l} <= 3'($random(seed));
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    a = 11'($random(seed));
    seta(a);
    rdseq(2);
    // page write that runs past the page end
    a = 11'($random(seed));
    a[3:0] = 4'hd;
    seta(a);
    for (i = 0; i < 18; i++) begin
      b = 8'($random(seed));
      wdat(b);
    end
    stop();
    repeat (4 * QTR + 8) @(posedge clk);
    chk("busy", 9'h001, {8'h00, busy});
    poll();
    a[3:0] = 4'h0;
    seta(a);
    rdseq(16);
    seta(11'h7fe);
    rdseq(3);
    rdseq(1);
    // protected write must be refused whole
    wp <= 1'b1;
    a = 11'($random(seed));
    seta(a);
    b = 8'($random(seed));
    wrx("protected", b, 1'b1);
    stop();
    repeat (4 * QTR + 8) @(posedge clk);
    chk("busy protected", 9'h000, {8'h00, busy});
    wp <= 1'b0;
    seta(a);
    rdseq(1);
    op(OP_START, 8'h00);
    wrx("other chip", tadr(3'h0, 1'b0) ^ 8'h40, 1'b1);
    stop();
    // answer buffer fills while the receiver stalls
    rsp_ready <= 1'b0;
    op(OP_START, 8'h00);
    op(OP_WRITE, tadr(3'h2, 1'b0));
    op(OP_WRITE, 8'h35);
    repeat (40 * QTR) @(posedge clk);
    chk("ready full", 9'h000, {8'h00, cmd_ready});
    rsp_ready <= 1'b1;
    rsp("addr", {tadr(3'h2, 1'b0), 1'b0});
    rsp("word", {8'h35, 1'b0});
    stop();
    mptr = 11'h235;
    rdseq(1);
    test_done();
  end
endmodule
`default_nettype wire
